// ---- rtl/macrocell_regs.svh ----
// register offsets, field positions, reset values and timing counts of the output cell block
`ifndef MACROCELL_REGS_SVH
`define MACROCELL_REGS_SVH

// ==========================================================
// register byte offsets (word index is offset / 4)
`define OFS_CTRL 12'h000
`define OFS_CELL_MODE 12'h004
`define OFS_SECURITY 12'h008
`define OFS_PRELOAD 12'h00C
`define OFS_STATUS 12'h010
`define OFS_SIG_LO 12'h014
`define OFS_SIG_HI 12'h018
`define OFS_ARRAY 12'h100
`define IDX_ARRAY 10'h040
`define IDX_ARRAY_END 10'h07F

// ==========================================================
// field positions
`define CTRL_REG_ALLOW 0
`define CTRL_EMULATION 1
`define SEC_SET 0
`define SEC_ERASE 1
`define PRELOAD_GO 0
`define STAT_STANDBY 16
`define STAT_SECURED 17
`define STAT_INVALID 18

// ==========================================================
// reset values: an erased part, every mode bit set; dedicated input on all cells but 3 and 4, which flag invalid
`define RST_CTRL 2'h1
`define RST_MODE 8'hFF
`define RST_POLARITY 8'h00
`define HSIZE_WORD 3'h2

// ==========================================================
// timing
`define CLK_PERIOD_NS 10
`define STANDBY_IDLE_NS 50
`define STANDBY_IDLE_CYCLES ((`STANDBY_IDLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/macrocell_pkg.sv ----
// types shared by the output cell block
package macrocell_pkg;

   // ==========================================================
   // standby watcher states
   typedef enum logic {
      WATCH_ACTIVE,
      WATCH_STANDBY
   } watch_state_type;

   // global and per-cell configuration word
   typedef struct packed {
      logic global_register_allow;
      logic global_emulation_select;
      logic [7:0] cell_mode_bit;
      logic [7:0] cell_polarity_bit;
   } config_word_type;

   // pin levels sampled from the board
   typedef struct packed {
      logic [7:0] in_pin;
      logic clk_pin;
      logic oe_n_pin;
      logic [7:0] io_in;
   } pin_sample_type;

endpackage

// ---- rtl/activity_standby.sv ----
// input-activity watcher that puts the cell array into standby
`timescale 1ns/10ps
`include "macrocell_regs.svh"

module activity_standby import macrocell_pkg::*; #(
   parameter int WIDTH = 17,
   parameter int IDLE_CYCLES = `STANDBY_IDLE_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic [WIDTH-1:0] activity,
   output logic standby
);

   typedef struct packed {
      watch_state_type state;
      logic [WIDTH-1:0] last;
      logic [7:0] idle;
   } watch_type;

   watch_type s_reg;
   watch_type s_next;
   logic change;

   // any input edge wakes at once, so leaving standby costs no cycle
   assign change = (activity != s_reg.last);
   assign standby = (s_reg.state == WATCH_STANDBY) && !change;

   // ==========================================================
   // idle counter and state
   always_comb begin
      s_next = s_reg;
      s_next.last = activity;
      case (s_reg.state)
         WATCH_ACTIVE: begin
            if (change || !enable) begin
               s_next.idle = 8'h00;
            end else if (s_reg.idle >= 8'(IDLE_CYCLES - 1)) begin
               s_next.state = WATCH_STANDBY;
            end else begin
               s_next.idle = s_reg.idle + 8'h01;
            end
         end
         WATCH_STANDBY: begin
            if (change || !enable) begin
               s_next.state = WATCH_ACTIVE;
               s_next.idle = 8'h00;
            end
         end
         default: begin
            s_next.state = WATCH_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

endmodule

// ---- rtl/output_cell_array.sv ----
// sum-of-products array with eight configurable output cells behind an AHB-Lite slave
//
// Behaviour
// - two global bits plus eight mode, eight polarity bits
// - emulation and mode bits steer four cell multiplexers
// - end cells use inverted register-allow on feedback
// - allow 0, emulation 1, mode 0: registered
// - register on clock rise, feedback Q, pin enable
// - allow 1, emulation 0, mode 0: combinatorial output
// - clock and enable pins feed end cells
// - non-registered I/O: seven terms, term enables
// - registered-device I/O: seven terms, term enables
// - dedicated input: buffer off, adjacent pin feedback
// - cells three and four lack input feedback
// - polarity bit one gives active-high output
// - flip-flops reset low, registered pins high
// - flip-flops preloadable from their output pins
// - preload still works when secured
// - security blocks readback and programming; erase clears
// - 64-bit signature always readable
// - standby after 50 ns idle, outputs held
// - any input change leaves standby at once
// - clock toggling alone does not wake cells
// - empty term high, contradictory term low
// - eight independently configurable cells
`timescale 1ns/10ps
`include "macrocell_regs.svh"

module output_cell_array import macrocell_pkg::*; #(
   parameter int CELLS = 8,
   parameter int TERMS = 8,
   parameter bit LOW_POWER = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [7:0] in_pin,
   input wire logic clk_pin,
   input wire logic oe_n_pin,
   input wire logic [7:0] io_in,
   output logic [7:0] io_out,
   output logic [7:0] io_oe,
   output logic standby
);

   localparam int COLS = 4 * CELLS;
   localparam int PTERMS = CELLS * TERMS;
   // erased configuration, each global bit taken from its own field position
   localparam config_word_type CFG_ERASED = '{1'(`RST_CTRL >> `CTRL_REG_ALLOW),
      1'(`RST_CTRL >> `CTRL_EMULATION), `RST_MODE, `RST_POLARITY};

   // whole block state, registered in one place
   typedef struct packed {
      config_word_type cfg;
      logic secured;
      logic [63:0] signature;
      logic [PTERMS-1:0][COLS-1:0] fuse;
      logic [CELLS-1:0] q;
      logic clk_prev;
      logic [CELLS-1:0] out;
      logic [CELLS-1:0] oe;
      logic wr_pend;
      logic [9:0] wr_idx;
      logic [31:0] rdata;
   } core_type;

   core_type s_reg;
   core_type s_next;
   pin_sample_type pins;
   logic [CELLS-1:0] fb;
   logic [CELLS-1:0] sum;
   logic [CELLS-1:0] level;
   logic [CELLS-1:0] enable;
   logic [CELLS-1:0] use_reg;
   logic [COLS-1:0] cols;
   logic invalid_cfg;

   assign pins = '{in_pin: in_pin, clk_pin: clk_pin, oe_n_pin: oe_n_pin, io_in: io_in};

   // ==========================================================
   // helpers

   // true and complement column of each array signal
   function automatic logic [COLS-1:0] build_cols(input logic [2*CELLS-1:0] sig);
      logic [COLS-1:0] c;
      c = '0;
      for (int i = 0; i < 2 * CELLS; i++) begin
         c[2*i] = sig[i];
         c[2*i+1] = !sig[i];
      end
      return c;
   endfunction

   // a term is the AND of every connected column
   function automatic logic eval_term(input logic [COLS-1:0] c, input logic [COLS-1:0] f);
      return &(c | ~f);
   endfunction

   // feedback multiplexer: pin next door, own pin or register
   function automatic logic feedback_mux(input logic ctl, input logic mode, input logic q,
                                         input logic own_pin, input logic adj_pin);
      logic r;
      r = adj_pin;
      if (ctl && !mode) begin
         r = q;
      end else if (ctl && mode) begin
         r = own_pin;
      end
      return r;
   endfunction

   // the five documented settings; anything else is flagged
   function automatic logic setting_ok(input config_word_type c, input int i);
      logic m;
      m = c.cell_mode_bit[i];
      if (!c.global_register_allow) begin
         return c.global_emulation_select;
      end else if (c.global_emulation_select) begin
         return m;
      end
      return !(m && (i == 3 || i == 4));
   endfunction

   // ==========================================================
   // array and cell multiplexers
   always_comb begin
      logic ctl;
      logic adj;
      logic m;
      logic term;
      ctl = 1'b0;
      adj = 1'b0;
      m = 1'b0;
      term = 1'b0;
      invalid_cfg = 1'b0;
      // feedback mux of every cell first, since the array reads all of them
      for (int i = 0; i < CELLS; i++) begin
         m = s_reg.cfg.cell_mode_bit[i];
         ctl = s_reg.cfg.global_emulation_select;
         if (i == 0) begin
            ctl = !s_reg.cfg.global_register_allow;
            adj = pins.oe_n_pin;
         end else if (i == CELLS - 1) begin
            ctl = !s_reg.cfg.global_register_allow;
            adj = pins.clk_pin;
         end else if (i == 3 || i == 4) begin
            adj = 1'b0;
         end else if (i < 3) begin
            adj = pins.io_in[i-1];
         end else begin
            adj = pins.io_in[i+1];
         end
         fb[i] = feedback_mux(ctl, m, s_reg.q[i], pins.io_in[i], adj);
         if (!setting_ok(s_reg.cfg, i)) begin
            invalid_cfg = 1'b1;
         end
      end
      cols = build_cols({fb, pins.in_pin});
      for (int i = 0; i < CELLS; i++) begin
         m = s_reg.cfg.cell_mode_bit[i];
         sum[i] = 1'b0;
         enable[i] = 1'b0;
         // product-term mux: term 0 leaves the OR gate when it drives the enable
         for (int t = 0; t < TERMS; t++) begin
            term = eval_term(cols, s_reg.fuse[i*TERMS+t]);
            if (t == 0 && s_reg.cfg.global_emulation_select && m) begin
               enable[i] = term;
            end else begin
               sum[i] = sum[i] | term;
            end
         end
         // enable mux: shared pin, own term, always on, always off
         if (s_reg.cfg.global_emulation_select && !m) begin
            enable[i] = !pins.oe_n_pin;
         end else if (!s_reg.cfg.global_emulation_select) begin
            enable[i] = !m;
         end
         // output mux and polarity gate
         use_reg[i] = s_reg.cfg.global_emulation_select && !m;
         if (use_reg[i]) begin
            level[i] = !s_reg.q[i];
         end else begin
            level[i] = sum[i] ^ !s_reg.cfg.cell_polarity_bit[i];
         end
      end
   end

   // ==========================================================
   // standby watcher; the clock pin is left out of its inputs
   activity_standby #(
      .WIDTH(2 * CELLS + 1),
      .IDLE_CYCLES(`STANDBY_IDLE_CYCLES)
   ) u_standby (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(LOW_POWER),
      .activity({pins.in_pin, pins.oe_n_pin, pins.io_in}),
      .standby(standby)
   );

   // ==========================================================
   // bus, programming, register and pin update
   always_comb begin
      logic take;
      logic [9:0] idx;
      logic [31:0] rd;
      logic rise;
      take = 1'b0;
      idx = 10'h000;
      rd = 32'h0000_0000;
      rise = 1'b0;
      s_next = s_reg;
      take = hsel && htrans[1] && hready;
      rise = pins.clk_pin && !s_reg.clk_prev;
      s_next.clk_prev = pins.clk_pin;
      // flip-flops clock on the clock pin rising; standby ignores it
      for (int i = 0; i < CELLS; i++) begin
         if (use_reg[i] && rise && !standby) begin
            s_next.q[i] = sum[i] ^ s_reg.cfg.cell_polarity_bit[i];
         end
      end
      // data phase of a write
      if (s_reg.wr_pend) begin
         idx = s_reg.wr_idx;
         if (idx == 10'(`OFS_SECURITY >> 2)) begin
            if (hwdata[`SEC_ERASE]) begin
               s_next.fuse = '0;
               s_next.signature = '0;
               s_next.secured = 1'b0;
               s_next.cfg = CFG_ERASED;
            end else if (hwdata[`SEC_SET]) begin
               s_next.secured = 1'b1;
            end
         end else if (idx == 10'(`OFS_PRELOAD >> 2) && hwdata[`PRELOAD_GO]) begin
            s_next.q = ~pins.io_in;
         end else if (!s_reg.secured) begin
            // programming is refused while secured
            if (idx == 10'(`OFS_CTRL >> 2)) begin
               s_next.cfg.global_register_allow = hwdata[`CTRL_REG_ALLOW];
               s_next.cfg.global_emulation_select = hwdata[`CTRL_EMULATION];
            end else if (idx == 10'(`OFS_CELL_MODE >> 2)) begin
               s_next.cfg.cell_mode_bit = hwdata[7:0];
               s_next.cfg.cell_polarity_bit = hwdata[15:8];
            end else if (idx == 10'(`OFS_SIG_LO >> 2)) begin
               s_next.signature[31:0] = hwdata;
            end else if (idx == 10'(`OFS_SIG_HI >> 2)) begin
               s_next.signature[63:32] = hwdata;
            end else if (idx >= `IDX_ARRAY && idx <= `IDX_ARRAY_END) begin
               s_next.fuse[6'(idx - `IDX_ARRAY)] = hwdata;
            end
         end
      end
      // address phase
      s_next.wr_pend = take && hwrite && (hsize == `HSIZE_WORD);
      s_next.wr_idx = haddr[11:2];
      // read data taken from the post-write view so write-then-read sees new data
      idx = haddr[11:2];
      if (idx == 10'(`OFS_CTRL >> 2) && !s_next.secured) begin
         rd[`CTRL_REG_ALLOW] = s_next.cfg.global_register_allow;
         rd[`CTRL_EMULATION] = s_next.cfg.global_emulation_select;
      end else if (idx == 10'(`OFS_CELL_MODE >> 2) && !s_next.secured) begin
         rd[15:0] = {s_next.cfg.cell_polarity_bit, s_next.cfg.cell_mode_bit};
      end else if (idx == 10'(`OFS_SECURITY >> 2)) begin
         rd[`SEC_SET] = s_next.secured;
      end else if (idx == 10'(`OFS_STATUS >> 2)) begin
         rd[15:0] = {s_reg.out, s_next.q};
         rd[`STAT_STANDBY] = standby;
         rd[`STAT_SECURED] = s_next.secured;
         rd[`STAT_INVALID] = invalid_cfg;
      end else if (idx == 10'(`OFS_SIG_LO >> 2)) begin
         rd = s_next.signature[31:0];
      end else if (idx == 10'(`OFS_SIG_HI >> 2)) begin
         rd = s_next.signature[63:32];
      end else if (idx >= `IDX_ARRAY && idx <= `IDX_ARRAY_END && !s_next.secured) begin
         rd = s_next.fuse[6'(idx - `IDX_ARRAY)];
      end
      if (take && !hwrite) begin
         s_next.rdata = rd;
      end
      // pins hold their last state through standby
      if (!standby) begin
         s_next.out = level;
         s_next.oe = enable;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.cfg <= CFG_ERASED;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs: zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign io_out = s_reg.out;
   assign io_oe = s_reg.oe;

endmodule

// ---- verification/output_cell_props.sv ----
// concurrent checks on the ports of the output cell block
`timescale 1ns/10ps

module output_cell_props import macrocell_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic [7:0] in_pin,
   input wire logic oe_n_pin,
   input wire logic [7:0] io_in,
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe,
   input wire logic standby
);
   // ==========================================================
   // quiet-time counter; clk_pin is left out since it never wakes the cells
   typedef struct packed {
      logic [16:0] prev;
      logic [3:0] cnt;
   } quiet_type;
   quiet_type q_reg;
   quiet_type q_next;
   logic [16:0] act;
   logic rd_take;
   assign act = {in_pin, oe_n_pin, io_in};
   assign rd_take = hsel && htrans[1] && hready && !hwrite;

   // saturate so a long idle spell does not wrap back to zero
   always_comb begin
      q_next = q_reg;
      q_next.prev = act;
      if (act != q_reg.prev) begin
         q_next.cnt = 4'h0;
      end else if (q_reg.cnt != 4'hF) begin
         q_next.cnt = q_reg.cnt + 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   // ==========================================================
   // properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence quiet_input;
      $stable(act);
   endsequence
   sequence asleep;
      standby;
   endsequence

   a_ready_always: assert property (hreadyout == 1'b1)
      else $error("hreadyout low");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("hresp not okay");
   a_read_data_holds: assert property (!$past(rd_take) |-> $stable(hrdata))
      else $error("hrdata moved without a read");
   a_standby_freezes_io: assert property ($past(standby) |-> $stable({io_out, io_oe}))
      else $error("outputs moved in standby");
   // five quiet 10 ns cycles make the 50 ns idle spell; a fresh edge still wakes
   a_quiet_enters_standby: assert property (q_reg.cnt == 4'h5 ##0 quiet_input |-> asleep)
      else $error("no standby after quiet inputs");
   a_standby_needs_quiet: assert property ($rose(standby) |-> q_reg.cnt == 4'h5)
      else $error("standby too early");
   a_change_wakes: assert property (!$stable(act) |-> (!standby) [*4])
      else $error("input change did not wake");
   a_clock_keeps_standby: assert property (asleep ##1 quiet_input |-> asleep)
      else $error("standby left without input change");
endmodule

bind output_cell_array output_cell_props u_output_cell_props (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hreadyout(hreadyout),
   .hrdata(hrdata),
   .hresp(hresp),
   .in_pin(in_pin),
   .oe_n_pin(oe_n_pin),
   .io_in(io_in),
   .io_out(io_out),
   .io_oe(io_oe),
   .standby(standby)
);

// ---- verification/board_model.sv ----
// board logic that resolves the level on each cell's I/O pin
`timescale 1ns/10ps

module board_model (
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe,
   input wire logic [7:0] board_level,
   output logic [7:0] io_in
);
   // ==========================================================
   // a driving cell sets its pin, otherwise the board driver does
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         io_in[i] = io_oe[i] ? io_out[i] : board_level[i];
      end
   end
endmodule

// ---- verification/test_output_cell_array.sv ----
// self-checking bench for the output cell block
`timescale 1ns/10ps
`include "macrocell_regs.svh"

module test_output_cell_array import macrocell_pkg::*; ;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = `HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic standby;
   logic [31:0] hrdata;
   logic [7:0] in_pin = 8'h00;
   logic clk_pin = 1'b0;
   logic oe_n_pin = 1'b0;
   logic [7:0] board_level = 8'h00;
   logic [7:0] io_in;
   logic [7:0] io_out;
   logic [7:0] io_oe;
   logic [31:0] rd;
   int n_errors = 0;
   int n_tests = 0;

   assign hready = hreadyout;
   always #5 hclk = ~hclk;

   output_cell_array u_output_cell_array (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .in_pin(in_pin), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .standby(standby));
   board_model u_board_model (.io_out(io_out), .io_oe(io_oe), .board_level(board_level),
      .io_in(io_in));

   // ==========================================================
   // reporting
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // ==========================================================
   // bus tasks; a stuck slave ends the run instead of hanging it
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         n_errors++;
         tally_and_finish();
      end
   endtask

   task automatic bus_op(input logic [11:0] a, input logic wr, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic bus_write(input logic [11:0] a, input logic [31:0] d);
      bus_op(a, 1'b1, d);
   endtask

   task automatic rd_check(input string what, input logic [11:0] a, input logic [31:0] exp);
      bus_op(a, 1'b0, 32'h0);
      check(what, rd, exp);
   endtask

   task automatic set_term(input int t, input logic [31:0] v);
      bus_write(12'(`OFS_ARRAY + 4 * t), v);
   endtask

   // a term on in_pin[0] true and complement is always low
   task automatic fill_terms();
      for (int t = 0; t < 64; t++) begin
         set_term(t, 32'h3);
      end
   endtask

   // ==========================================================
   // pin tasks; in_pin[7] feeds no term and is flipped only to leave standby
   task automatic pins(input logic [7:0] i, input logic oe_n, input logic [7:0] b,
      input logic c);
      @(posedge hclk);
      in_pin <= {~in_pin[7], i[6:0]};
      oe_n_pin <= oe_n;
      board_level <= b;
      clk_pin <= c;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask

   task automatic look(input string what, input logic [7:0] mask, input logic [7:0] e_out,
      input logic [7:0] e_oe);
      check(what, {16'h0, io_oe, io_out & mask}, {16'h0, e_oe, e_out});
   endtask

   task automatic clk_pulse();
      @(posedge hclk);
      in_pin[7] <= ~in_pin[7];
      clk_pin <= 1'b1;
      repeat (2) @(posedge hclk);
      clk_pin <= 1'b0;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
   endtask

   // in_pin[7] is flipped so standby cannot freeze the loaded outputs
   task automatic preload(input logic [7:0] b);
      @(posedge hclk);
      board_level <= b;
      oe_n_pin <= 1'b1;
      in_pin[7] <= ~in_pin[7];
      bus_write(`OFS_PRELOAD, 32'h1);
      pins(8'h00, 1'b1, b, 1'b0);
   endtask

   task automatic do_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      do_reset();
      rd_check("ctrl reset", `OFS_CTRL, {30'h0, `RST_CTRL});
      rd_check("mode reset", `OFS_CELL_MODE, {16'h0, `RST_POLARITY, `RST_MODE});
      bus_write(12'h020, 32'hFFFF_FFFF);
      rd_check("unmapped", 12'h020, 32'h0);
      pins(8'h00, 1'b0, 8'h00, 1'b0);
      look("inputs off", 8'h00, 8'h00, 8'h00);
      $display("reset test done");
      bus_write(`OFS_CTRL, 32'h0);
      bus_op(`OFS_STATUS, 1'b0, 32'h0);
      check("invalid cfg", {31'h0, rd[`STAT_INVALID]}, 32'h1);
      // cells 0, 1, 7 inputs; 2..4 and 6 outputs watching feedback paths, 5 watching in_pin[0]
      bus_write(`OFS_CTRL, 32'h1);
      bus_write(`OFS_CELL_MODE, 32'h0000_FF83);
      fill_terms();
      set_term(16, 32'h0004_0000);
      set_term(24, 32'h0001_0000);
      set_term(32, 32'h0040_0000);
      set_term(40, 32'h0000_0001);
      set_term(48, 32'h4000_0000);
      for (int k = 0; k < 2; k++) begin
         pins({7'h0, k[0]}, k[0], {8{k[0]}}, k[0]);
         look("comb out", 8'h7C, k ? 8'h6C : 8'h00, 8'h7C);
      end
      bus_write(`OFS_CELL_MODE, 32'h0000_0083);
      pins(8'h01, 1'b1, 8'hFF, 1'b1);
      look("active low", 8'h7C, 8'h10, 8'h7C);
      set_term(32, 32'h0);
      pins(8'h01, 1'b1, 8'hFF, 1'b1);
      look("empty term", 8'h7C, 8'h00, 8'h7C);
      $display("combinatorial test done");
      // I/O cells: cell 2 enable on in_pin[1], cell 3 reads the cell 2 pin
      bus_write(`OFS_CELL_MODE, 32'h0000_FFFF);
      fill_terms();
      set_term(16, 32'h4);
      set_term(17, 32'h1);
      set_term(25, 32'h0010_0000);
      for (int m = 3; m >= 2; m--) begin
         bus_write(`OFS_CTRL, 32'(m));
         for (int c = 0; c < 4; c++) begin
            pins({6'h0, c[1:0]}, 1'b0, 8'hFF, 1'b0);
            look("io cell", 8'h0C, {4'h0, c[1] ? c[0] : 1'b1, c[0], 2'h0},
               {5'h0, c[1], 2'h0});
         end
      end
      $display("io test done");
      do_reset();
      bus_write(`OFS_CTRL, 32'h2);
      bus_write(`OFS_CELL_MODE, 32'h0000_FF00);
      fill_terms();
      set_term(8, 32'h1);
      pins(8'h00, 1'b0, 8'h00, 1'b0);
      look("power-up", 8'hFF, 8'hFF, 8'hFF);
      pins(8'h00, 1'b1, 8'h00, 1'b0);
      look("enable pin", 8'hFF, 8'hFF, 8'h00);
      pins(8'h01, 1'b0, 8'h00, 1'b0);
      look("no clock", 8'hFF, 8'hFF, 8'hFF);
      clk_pulse();
      look("clocked", 8'hFF, 8'h02, 8'hFF);
      pins(8'h00, 1'b0, 8'h00, 1'b0);
      look("held", 8'hFF, 8'h02, 8'hFF);
      clk_pulse();
      look("clocked low", 8'hFF, 8'h00, 8'hFF);
      $display("registered test done");
      preload(8'hA5);
      look("preload", 8'hFF, 8'hA5, 8'h00);
      bus_write(`OFS_SIG_LO, 32'h1234_5678);
      bus_write(`OFS_SIG_HI, 32'h9ABC_DEF0);
      bus_write(`OFS_SECURITY, 32'h1);
      bus_op(`OFS_STATUS, 1'b0, 32'h0);
      check("secured", {31'h0, rd[`STAT_SECURED]}, 32'h1);
      check("valid cfg", {31'h0, rd[`STAT_INVALID]}, 32'h0);
      rd_check("ctrl hidden", `OFS_CTRL, 32'h0);
      bus_write(`OFS_SIG_LO, 32'h0);
      rd_check("signature", `OFS_SIG_LO, 32'h1234_5678);
      rd_check("signature high", `OFS_SIG_HI, 32'h9ABC_DEF0);
      preload(8'h3C);
      look("secured preload", 8'hFF, 8'h3C, 8'h00);
      bus_write(`OFS_SECURITY, 32'h2);
      rd_check("erased ctrl", `OFS_CTRL, {30'h0, `RST_CTRL});
      rd_check("erased signature", `OFS_SIG_LO, 32'h0);
      $display("security test done");
      repeat (10) @(posedge hclk);
      @(negedge hclk);
      check("standby", {31'h0, standby}, 32'h1);
      for (int i = 0; i < 6; i++) begin
         @(posedge hclk);
         clk_pin <= ~clk_pin;
      end
      @(negedge hclk);
      check("clock only", {31'h0, standby}, 32'h1);
      @(posedge hclk);
      in_pin[1] <= ~in_pin[1];
      @(negedge hclk);
      check("woken", {31'h0, standby}, 32'h0);
      $display("standby test done");
      tally_and_finish();
   end
endmodule
